// [core/lsfs_consts.svh]
// timing, register map and field constants of the load switch fault sequencer
`ifndef LSFS_CONSTS_SVH
`define LSFS_CONSTS_SVH

`define LSFS_CLK_HZ         25000000
`define LSFS_HZ_PER_MHZ     1000000
`define LSFS_OC_PERSIST_US  7000
`define LSFS_RETRY_US       150000
`define LSFS_RAMP_US        400
`define LSFS_TMR_W          24

`define LSFS_AW             4
`define LSFS_DW             8
`define LSFS_ADDR_STATUS    4'h0
`define LSFS_ADDR_MASK      4'h4
`define LSFS_ADDR_STATE     4'h8
`define LSFS_ADDR_CTRL      4'hc

`define LSFS_EV_OC          0
`define LSFS_EV_OT          1
`define LSFS_EV_RETRY       2
`define LSFS_EV_PGOOD       3
`define LSFS_CTRL_SWOFF     0
`define LSFS_MASK_RST       8'h00
`define LSFS_CTRL_RST       8'h00

`endif

// [core/lsfs_pkg.sv]
// types shared by the load switch fault sequencer
package lsfs_pkg;

    typedef enum logic [5:0] {
        LSFS_OFF     = 6'h01,
        LSFS_RAMP    = 6'h02,
        LSFS_ON      = 6'h04,
        LSFS_RETRY   = 6'h08,
        LSFS_LATCHED = 6'h10,
        LSFS_OTEMP   = 6'h20
    } lsfs_state_t;

    // synchronised pin levels
    typedef struct packed {
        logic enable;
        logic overcurrent;
        logic overtemp;
        logic out_above;
        logic latch_mode;
        logic ramp_cap;
    } lsfs_pins_t;

    // sticky events
    typedef struct packed {
        logic [3:0] spare;
        logic       pgood;
        logic       retry;
        logic       ot;
        logic       oc;
    } lsfs_events_t;

endpackage

// [core/lsfs_sync.sv]
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module lsfs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// [core/lsfs_timer.sv]
// loadable down counter that pulses once when its interval runs out
`timescale 1ns/10ps
module lsfs_timer #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic         clr,
    input  wire logic [W-1:0] len,
    output logic              done,
    output logic              busy
);
    logic [W-1:0] cnt_q;

    assign done = (cnt_q == W'(1));
    assign busy = (cnt_q != '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= len;
        end else if (busy) begin
            cnt_q <= cnt_q - W'(1);
        end
    end
endmodule

// [core/lsfs_top.sv]
// load switch fault sequencer: on/off sequencing, fault timers, flags, registers
//
// Contract
// - over-current present longer than 7 ms turns switch off, pulls fault low
// - auto-retry: after over-current trip, switch on again after 150 ms if enabled
// - latch-off: after over-current trip stay off until enable toggles or power cycles
// - current limit engages within 1 us of over-current; persistence timer starts then
// - host holds enable high to operate; switch stays off while enable low
// - fault indicator driven low while a fault is in effect, else released
// - output-good indicator driven low once output passes 90 % of supply
// - over-temperature turns the switch off at once, no persistence delay
// - auto-retry: restart 150 ms after temperature clears, fault held low meanwhile
// - auto-retry: fault indicator released 150 ms after over-temperature ended
// - latch-off: after over-temperature stay off, no retry, fault stays low
// - without ramp capacitor, turn-on ramp lasts a default 400 us
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "lsfs_consts.svh"
module lsfs_top #(
    parameter int unsigned CLK_HZ    = `LSFS_CLK_HZ,
    parameter int unsigned OC_CYC    = `LSFS_OC_PERSIST_US * (CLK_HZ / `LSFS_HZ_PER_MHZ),
    parameter int unsigned RETRY_CYC = `LSFS_RETRY_US * (CLK_HZ / `LSFS_HZ_PER_MHZ),
    parameter int unsigned RAMP_CYC  = `LSFS_RAMP_US * (CLK_HZ / `LSFS_HZ_PER_MHZ)
) (
    input  wire logic                  MCLK,
    input  wire logic                  RSTN,
    input  wire logic                  ENABLE,
    input  wire logic                  OVERCURRENT_PROTECTION,
    input  wire logic                  OVERTEMP_EVENT,
    input  wire logic                  OUT_ABOVE_THRESHOLD,
    input  wire logic                  LATCH_MODE,
    input  wire logic                  RAMP_CAP_FITTED,
    output logic                       SWITCH_ON,
    output logic                       CURRENT_LIMIT_SET,
    output logic                       RAMP_ACTIVE,
    output logic                       FAULT_INDICATOR_N_O,
    output logic                       FAULT_INDICATOR_N_OE,
    output logic                       OUTPUT_GOOD_N_O,
    output logic                       OUTPUT_GOOD_N_OE,
    input  wire logic [`LSFS_AW-1:0]   REG_ADDR,
    input  wire logic [`LSFS_DW-1:0]   REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic      [`LSFS_DW-1:0]   REG_RDATA,
    output logic                       IRQ
);
    localparam int TW = `LSFS_TMR_W;

    // ------------------------------------------------------------
    // reset release and pin synchronisation
    // ------------------------------------------------------------
    logic              rst_meta_q;
    logic              rst_n;
    lsfs_pkg::lsfs_pins_t pins_raw;
    lsfs_pkg::lsfs_pins_t pins;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    assign pins_raw = '{enable:      ENABLE,
                        overcurrent: OVERCURRENT_PROTECTION,
                        overtemp:    OVERTEMP_EVENT,
                        out_above:   OUT_ABOVE_THRESHOLD,
                        latch_mode:  LATCH_MODE,
                        ramp_cap:    RAMP_CAP_FITTED};

    lsfs_sync #(
        .W ($bits(lsfs_pkg::lsfs_pins_t))
    ) u_sync (
        .clk   (MCLK),
        .rst_n (rst_n),
        .din   (pins_raw),
        .dout  (pins)
    );

    // ------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------
    lsfs_pkg::lsfs_state_t state_q;
    lsfs_pkg::lsfs_state_t state_d;
    lsfs_pkg::lsfs_events_t status_q;
    lsfs_pkg::lsfs_events_t status_d;
    lsfs_pkg::lsfs_events_t events;
    logic [`LSFS_DW-1:0] mask_q;
    logic [`LSFS_DW-1:0] ctrl_q;
    logic [`LSFS_DW-1:0] rdata_d;
    logic                oc_prev_q;
    logic                pg_prev_q;
    logic                sel_status;
    logic                sel_mask;
    logic                sel_state;
    logic                sel_ctrl;
    logic                en_eff;
    logic                sw_active;
    logic                oc_trip;
    logic                oc_start;
    logic                ot_now;
    logic                latch_mode;
    logic                ph_start;
    logic [TW-1:0]       ph_len;
    logic                ph_done;
    logic                ph_busy;
    logic                oc_done;
    logic                ramp_done;
    logic                fault_on;

    assign sel_status = (REG_ADDR == `LSFS_ADDR_STATUS);
    assign sel_mask   = (REG_ADDR == `LSFS_ADDR_MASK);
    assign sel_state  = (REG_ADDR == `LSFS_ADDR_STATE);
    assign sel_ctrl   = (REG_ADDR == `LSFS_ADDR_CTRL);

    assign en_eff     = pins.enable & ~ctrl_q[`LSFS_CTRL_SWOFF];
    assign latch_mode = pins.latch_mode;
    assign ot_now     = pins.overtemp;
    assign sw_active  = (state_q == lsfs_pkg::LSFS_RAMP) || (state_q == lsfs_pkg::LSFS_ON);

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    // persistence starts as limiting engages
    assign oc_start = sw_active & pins.overcurrent & ~oc_prev_q;
    assign oc_trip  = sw_active & pins.overcurrent & oc_done & ~ot_now;

    lsfs_timer #(
        .W (TW)
    ) u_oc_tmr (
        .clk   (MCLK),
        .rst_n (rst_n),
        .start (oc_start),
        .clr   (~(sw_active & pins.overcurrent)),
        .len   (TW'(OC_CYC)),
        .done  (oc_done),
        .busy  ()
    );

    assign ph_start = (state_d != state_q) &&
                      ((state_d == lsfs_pkg::LSFS_RETRY) || (state_d == lsfs_pkg::LSFS_RAMP));
    assign ph_len   = (state_d == lsfs_pkg::LSFS_RETRY) ? TW'(RETRY_CYC) : TW'(RAMP_CYC);

    lsfs_timer #(
        .W (TW)
    ) u_ph_tmr (
        .clk   (MCLK),
        .rst_n (rst_n),
        .start (ph_start),
        .clr   (1'b0),
        .len   (ph_len),
        .done  (ph_done),
        .busy  (ph_busy)
    );

    // ramp ends on timer, or on output good when a capacitor sets it
    assign ramp_done = pins.ramp_cap ? pins.out_above : ph_done;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            lsfs_pkg::LSFS_OFF: begin
                if (ot_now) begin
                    state_d = lsfs_pkg::LSFS_OTEMP;
                end else if (en_eff) begin
                    state_d = lsfs_pkg::LSFS_RAMP;
                end
            end
            lsfs_pkg::LSFS_RAMP, lsfs_pkg::LSFS_ON: begin
                if (ot_now) begin
                    state_d = lsfs_pkg::LSFS_OTEMP;
                end else if (oc_trip) begin
                    state_d = latch_mode ? lsfs_pkg::LSFS_LATCHED : lsfs_pkg::LSFS_RETRY;
                end else if (!en_eff) begin
                    state_d = lsfs_pkg::LSFS_OFF;
                end else if (state_q == lsfs_pkg::LSFS_RAMP && ramp_done) begin
                    state_d = lsfs_pkg::LSFS_ON;
                end
            end
            lsfs_pkg::LSFS_RETRY: begin
                // restart after timeout if still enabled
                if (ot_now) begin
                    state_d = lsfs_pkg::LSFS_OTEMP;
                end else if (ph_done) begin
                    state_d = en_eff ? lsfs_pkg::LSFS_RAMP : lsfs_pkg::LSFS_OFF;
                end
            end
            lsfs_pkg::LSFS_LATCHED: begin
                // only en_eff going low (enable low or the CTRL switch-off bit set) releases the latch
                if (!en_eff && !ot_now) begin
                    state_d = lsfs_pkg::LSFS_OFF;
                end
            end
            lsfs_pkg::LSFS_OTEMP: begin
                // retry wait starts when temperature clears
                // latch-off goes to the latch, no retry
                if (!ot_now) begin
                    state_d = latch_mode ? lsfs_pkg::LSFS_LATCHED : lsfs_pkg::LSFS_RETRY;
                end
            end
            default: begin
                state_d = lsfs_pkg::LSFS_OFF;
            end
        endcase
    end

    // fault in effect while tripped, waiting or latched
    assign fault_on = (state_d == lsfs_pkg::LSFS_RETRY) || (state_d == lsfs_pkg::LSFS_LATCHED) ||
                      (state_d == lsfs_pkg::LSFS_OTEMP);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= lsfs_pkg::LSFS_OFF;
            oc_prev_q <= 1'b0;
            pg_prev_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            oc_prev_q <= sw_active & pins.overcurrent;
            pg_prev_q <= pins.out_above;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            SWITCH_ON            <= 1'b0;
            CURRENT_LIMIT_SET    <= 1'b0;
            RAMP_ACTIVE          <= 1'b0;
            FAULT_INDICATOR_N_OE <= 1'b0;
            OUTPUT_GOOD_N_OE     <= 1'b0;
        end else begin
            SWITCH_ON            <= (state_d == lsfs_pkg::LSFS_RAMP) ||
                                    (state_d == lsfs_pkg::LSFS_ON);
            // limit engages on first sampled over-current
            CURRENT_LIMIT_SET    <= sw_active & pins.overcurrent;
            RAMP_ACTIVE          <= (state_d == lsfs_pkg::LSFS_RAMP);
            FAULT_INDICATOR_N_OE <= fault_on;
            OUTPUT_GOOD_N_OE     <= pins.out_above;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_INDICATOR_N_O <= 1'b0;
            OUTPUT_GOOD_N_O     <= 1'b0;
        end else begin
            FAULT_INDICATOR_N_O <= 1'b0;
            OUTPUT_GOOD_N_O     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // events, status and interrupt
    // ------------------------------------------------------------
    assign events = '{spare: 4'h0,
                      pgood: pins.out_above & ~pg_prev_q,
                      retry: (state_q == lsfs_pkg::LSFS_RETRY) && ph_done,
                      ot:    ot_now && (state_q != lsfs_pkg::LSFS_OTEMP)
                             && (state_d == lsfs_pkg::LSFS_OTEMP),
                      oc:    oc_trip};

    // new events win over the read clear
    assign status_d = lsfs_pkg::lsfs_events_t'(((REG_RD && sel_status) ? `LSFS_DW'(0) : status_q)
                                               | events);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
            IRQ      <= 1'b0;
        end else begin
            status_q <= status_d;
            IRQ      <= |(status_d & mask_q);
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `LSFS_MASK_RST;
            ctrl_q <= `LSFS_CTRL_RST;
        end else if (REG_WR) begin
            if (sel_mask) begin
                mask_q <= REG_WDATA;
            end
            if (sel_ctrl) begin
                ctrl_q <= REG_WDATA;
            end
        end
    end

    assign rdata_d = !REG_RD    ? `LSFS_DW'(0) :
                     sel_status ? status_q :
                     sel_mask   ? mask_q :
                     sel_state  ? {SWITCH_ON, FAULT_INDICATOR_N_OE, latch_mode, state_q[4:0]} :
                     sel_ctrl   ? ctrl_q : `LSFS_DW'(0);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_trip;
        oc_trip;
    endsequence

    sequence s_off_flagged;
        !SWITCH_ON && FAULT_INDICATOR_N_OE;
    endsequence

    property p_oc_trip;
        @(posedge MCLK) disable iff (!rst_n) s_trip |=> s_off_flagged;
    endproperty
    a_oc_trip: assert property (p_oc_trip) else $error("over-current trip left switch on");

    property p_retry_on;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_RETRY) && ph_done && en_eff && !ot_now
            |=> (state_q == lsfs_pkg::LSFS_RAMP) && SWITCH_ON;
    endproperty
    a_retry_on: assert property (p_retry_on) else $error("no restart after retry wait");

    property p_latch_hold;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_LATCHED) && en_eff |=> !SWITCH_ON && FAULT_INDICATOR_N_OE;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched switch came on");

    property p_limit_fast;
        @(posedge MCLK) disable iff (!rst_n)
            sw_active && pins.overcurrent && !ot_now |=> CURRENT_LIMIT_SET ##1 $past(oc_prev_q);
    endproperty
    a_limit_fast: assert property (p_limit_fast) else $error("current limit late");

    property p_en_low;
        @(posedge MCLK) disable iff (!rst_n) !en_eff [*2] |=> !SWITCH_ON;
    endproperty
    a_en_low: assert property (p_en_low) else $error("switch on with enable low");

    property p_flag_fault;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_OTEMP) || (state_q == lsfs_pkg::LSFS_LATCHED)
            |-> FAULT_INDICATOR_N_OE && !FAULT_INDICATOR_N_O;
    endproperty
    a_flag_fault: assert property (p_flag_fault) else $error("fault indicator released");

    property p_pgood;
        @(posedge MCLK) disable iff (!rst_n)
            $rose(pins.out_above) |=> OUTPUT_GOOD_N_OE ##0 (status_q.pgood || $past(REG_RD));
    endproperty
    a_pgood: assert property (p_pgood) else $error("output good not pulled low");

    property p_ot_off;
        @(posedge MCLK) disable iff (!rst_n) ot_now |=> !SWITCH_ON && FAULT_INDICATOR_N_OE;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("switch on during over-temperature");

    property p_ot_wait;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_OTEMP) && !ot_now && !latch_mode
            |=> (state_q == lsfs_pkg::LSFS_RETRY) && FAULT_INDICATOR_N_OE && ph_busy;
    endproperty
    a_ot_wait: assert property (p_ot_wait) else $error("thermal retry wait not started");

    property p_ot_release;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_RETRY) && ph_done && !ot_now |=> !FAULT_INDICATOR_N_OE;
    endproperty
    a_ot_release: assert property (p_ot_release) else $error("fault not released");

    property p_ot_latch;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_OTEMP) && latch_mode |=> (state_q != lsfs_pkg::LSFS_RETRY)
            && !SWITCH_ON;
    endproperty
    a_ot_latch: assert property (p_ot_latch) else $error("latch-off retried after heat");

    // cycles spent in the ramp so far, for the ramp length check
    logic [TW-1:0] ramp_age_q;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ramp_age_q <= '0;
        end else begin
            ramp_age_q <= (state_q == lsfs_pkg::LSFS_RAMP) ? ramp_age_q + TW'(1) : '0;
        end
    end

    property p_ramp_len;
        @(posedge MCLK) disable iff (!rst_n)
            (state_q == lsfs_pkg::LSFS_RAMP) && (state_d == lsfs_pkg::LSFS_ON) && !pins.ramp_cap
            |-> ramp_age_q == TW'(RAMP_CYC - 1);
    endproperty
    a_ramp_len: assert property (p_ramp_len) else $error("wrong default ramp length");

endmodule

// [dv/lsfs_host.sv]
// host model: drives the enable request and pulls up the open-drain flags
`timescale 1ns/10ps
module lsfs_host (
    input  wire logic clk,
    input  wire logic en_req,
    input  wire logic flt_oe,
    input  wire logic flt_o,
    input  wire logic good_oe,
    input  wire logic good_o,
    output logic      enable,
    output logic      fault_n,
    output logic      good_n
);
    always @(posedge clk) begin
        enable <= en_req;
    end
    assign fault_n = flt_oe ? flt_o : 1'b1;
    assign good_n  = good_oe ? good_o : 1'b1;
endmodule

// [dv/lsfs_top_tb.sv]
// self-checking bench of the load switch fault sequencer
`timescale 1ns/10ps
`include "lsfs_consts.svh"
module lsfs_top_tb;
    localparam int OC = 20;
    localparam int RT = 40;
    localparam int RP = 10;
    logic       mclk = 1'b0, rstn = 1'b0, en_req = 1'b0, oc = 1'b0, ot = 1'b0;
    logic       above = 1'b0, latch = 1'b0, rcap = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic       enable, sw_on, current_limit_set, ramp, f_o, f_oe, g_o, g_oe, irq, fault_n, good_n;
    int         num_errors = 0, check_count = 0, seed = 22, n;

    always #20 mclk = ~mclk;

    lsfs_top #(.OC_CYC(OC), .RETRY_CYC(RT), .RAMP_CYC(RP)) u_dut (
        .MCLK(mclk), .RSTN(rstn), .ENABLE(enable), .OVERCURRENT_PROTECTION(oc),
        .OVERTEMP_EVENT(ot), .OUT_ABOVE_THRESHOLD(above), .LATCH_MODE(latch),
        .RAMP_CAP_FITTED(rcap), .SWITCH_ON(sw_on), .CURRENT_LIMIT_SET(current_limit_set),
        .RAMP_ACTIVE(ramp), .FAULT_INDICATOR_N_O(f_o), .FAULT_INDICATOR_N_OE(f_oe),
        .OUTPUT_GOOD_N_O(g_o), .OUTPUT_GOOD_N_OE(g_oe), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq));

    lsfs_host u_host (
        .clk(mclk), .en_req(en_req), .flt_oe(f_oe), .flt_o(f_o), .good_oe(g_oe),
        .good_o(g_o), .enable(enable), .fault_n(fault_n), .good_n(good_n));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? sw_on : (s == 1 ? fault_n : ramp);
    endfunction
    // bounded wait on switch (0), fault flag (1) or ramp (2)
    task automatic wt(input int s, input logic val, input int lim, output int c);
        c = 0;
        while (pick(s) !== val && c < lim) begin
            cyc(1);
            c++;
        end
        if (pick(s) !== val) begin
            chk("wait_bound", 8'h01, 8'h00);
            complete_run();
        end
    endtask
    task automatic win(input string nm, input int c, input int lo, input int hi);
        chk(nm, 8'((c >= lo && c <= hi) ? c : lo), 8'(c));
    endtask
    task automatic rr(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cyc(16);
        rstn <= 1'b1;
        cyc(6);
        rr(`LSFS_ADDR_MASK, v);
        chk("mask_rst", `LSFS_MASK_RST, v);
        rr(`LSFS_ADDR_CTRL, v);
        chk("ctrl_rst", `LSFS_CTRL_RST, v);
        wreg(`LSFS_ADDR_MASK, 8'h0f);
        rr(`LSFS_ADDR_MASK, v);
        chk("mask_rw", 8'h0f, v);
        rr(4'h2, v);
        chk("unmapped", 8'h00, v);
        wreg(`LSFS_ADDR_STATE, 8'hff);
        rr(`LSFS_ADDR_STATE, v);
        chk("state_off", 8'h01, v);
        $display("test registers done");
        en_req <= 1'b1;
        wt(2, 1'b1, 20, n);
        wt(2, 1'b0, 40, n);
        win("ramp_len", n, RP - 1, RP + 2);
        wt(0, 1'b1, 20, n);
        above <= 1'b1;
        cyc(5);
        chk("good_n", 8'h00, good_n);
        above <= 1'b0;
        wreg(`LSFS_ADDR_CTRL, 8'h01);
        cyc(4);
        chk("sw_off_ctrl", 8'h00, sw_on);
        chk("good_rel", 8'h01, good_n);
        wreg(`LSFS_ADDR_CTRL, 8'h00);
        wt(0, 1'b1, RP + 20, n);
        $display("test turn-on done");
        repeat (6) begin
            oc <= 1'b1;
            cyc(1 + ($unsigned($random(seed)) % (OC - 4)));
            oc <= 1'b0;
            cyc(3);
            chk("burst_on", 8'h01, sw_on);
        end
        oc <= 1'b1;
        cyc(4);
        chk("current_limit_set", 8'h01, current_limit_set);
        wt(0, 1'b0, OC + 20, n);
        win("oc_trip", n + 4, OC, OC + 8);
        oc <= 1'b0;
        cyc(2);
        chk("oc_flt", 8'h00, fault_n);
        wt(1, 1'b1, RT + 20, n);
        win("oc_retry", n + 2, RT - 1, RT + 5);
        wt(0, 1'b1, RP + 20, n);
        $display("test auto over-current done");
        ot <= 1'b1;
        wt(0, 1'b0, 5, n);
        cyc(2);
        chk("ot_flt", 8'h00, fault_n);
        cyc(20);
        ot <= 1'b0;
        wt(1, 1'b1, RT + 20, n);
        win("ot_release", n, RT, RT + 6);
        wt(0, 1'b1, RP + 20, n);
        $display("test auto over-temperature done");
        en_req <= 1'b0;
        wt(0, 1'b0, 6, n);
        latch <= 1'b1;
        cyc(8);
        en_req <= 1'b1;
        wt(0, 1'b1, RP + 20, n);
        rr(`LSFS_ADDR_STATUS, v);
        chk("st_all", 8'h0f, v);
        oc <= 1'b1;
        wt(0, 1'b0, OC + 20, n);
        oc <= 1'b0;
        cyc(3);
        chk("irq_set", 8'h01, irq);
        cyc(RT + RP + 10);
        chk("latch_oc_off", 8'h00, sw_on);
        chk("latch_oc_flt", 8'h00, fault_n);
        rr(`LSFS_ADDR_STATUS, v);
        chk("st_oc", 8'h01, v[`LSFS_EV_OC]);
        cyc(2);
        chk("irq_clr", 8'h00, irq);
        en_req <= 1'b0;
        cyc(6);
        en_req <= 1'b1;
        wt(0, 1'b1, RP + 20, n);
        ot <= 1'b1;
        wt(0, 1'b0, 5, n);
        cyc(10);
        ot <= 1'b0;
        cyc(RT + RP + 10);
        chk("latch_ot_off", 8'h00, sw_on);
        chk("latch_ot_flt", 8'h00, fault_n);
        en_req <= 1'b0;
        cyc(6);
        en_req <= 1'b1;
        wt(0, 1'b1, RP + 20, n);
        $display("test latch-off done");
        en_req <= 1'b0;
        wt(0, 1'b0, 6, n);
        rcap <= 1'b1;
        cyc(4);
        en_req <= 1'b1;
        wt(2, 1'b1, 20, n);
        cyc(RP + 5);
        chk("ramp_cap_hold", 8'h01, ramp);
        above <= 1'b1;
        wt(2, 1'b0, 6, n);
        $display("test ramp capacitor done");
        complete_run();
    end
endmodule
